// >>> rtl/bdm_pkg.sv
package bdm_pkg;

  localparam int DATA_W        = 8;
  localparam int ADDR_W        = 14;
  localparam int LOW_W         = 8;
  localparam int HIGH_W        = 6;
  localparam int NUM_SEL       = 8;
  localparam int NUM_OUT_GRP   = 3;
  localparam int NUM_OUT_PORTS = 24;

  localparam logic [7:0] LOW_RST  = 8'h00;
  localparam logic [5:0] HIGH_RST = 6'h00;
  localparam logic [1:0] CC_RST   = 2'h0;

  localparam int ROM_SEL_LSB  = 8;
  localparam int ROM_BRD_LSB  = 11;
  localparam int RAM_SEL_LSB  = 10;
  localparam int PORT_SEL_LSB = 9;
  localparam int UPPER_LSB    = 12;

  localparam logic [2:0] ROM_BRD_CODE_RST = 3'h0;
  localparam logic [2:0] RAM_BANK_RST     = 3'h0;

  localparam logic [1:0] OUT_GRP_10 = 2'h2;
  localparam logic [1:0] OUT_GRP_11 = 2'h3;
  localparam logic [1:0] OUT_GRP_01 = 2'h1;

  typedef struct packed {
    logic [1:0] cycle_code;
    logic [5:0] high;
    logic [7:0] low;
  } bdm_addr_s;

  typedef struct packed {
    logic bus_switch_enable;
    logic processor_drives_bus;
    logic latched_low_onto_bus_n;
    logic memory_read_gate;
    logic write_n;
    logic input_strobe_n;
    logic output_strobe_n;
  } bdm_ctrl_s;

endpackage : bdm_pkg

// >>> rtl/bdm_addr_latch.sv
`timescale 1ns/100ps
module bdm_addr_latch
  import bdm_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             strobe,
  input  wire logic [WIDTH-1:0] load_data,
  input  wire logic             clear,
  input  wire logic             increment,
  input  wire logic             carry_in,
  output logic      [WIDTH-1:0] value,
  output logic                  carry_out
);

  typedef struct packed {
    logic [WIDTH-1:0] val;
  } bdm_latch_s;

  bdm_latch_s s_q;
  bdm_latch_s s_d;

  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d.val = '0;
    end else if (strobe) begin
      s_d.val = load_data;
    end else if (increment && carry_in) begin
      s_d.val = s_q.val + WIDTH'(1);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q.val <= RST_VAL;
    end else begin
      s_q <= s_d;
    end
  end

  assign value     = s_q.val;
  assign carry_out = carry_in && (&s_q.val);

endmodule : bdm_addr_latch

// >>> rtl/bdm_out_latch.sv
`timescale 1ns/100ps
module bdm_out_latch
  import bdm_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             strobe,
  input  wire logic [WIDTH-1:0] data_in,
  output logic      [WIDTH-1:0] data_out
);

  typedef struct packed {
    logic [WIDTH-1:0] val;
  } bdm_olatch_s;

  bdm_olatch_s s_q;
  bdm_olatch_s s_d;

  always_comb begin
    s_d = s_q;
    if (strobe) begin
      s_d.val = data_in;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q.val <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign data_out = s_q.val;

endmodule : bdm_out_latch

// >>> rtl/bdm_bridge.sv
`timescale 1ns/100ps
// What this block does
// - Switch enable connects processor and system buses
// - Direction control picks bus switch flow
// - Upper decode high when bit 12/13 set
// - Low strobe captures address bits 0-7
// - High strobe captures bits 8-13, cycle code
// - External clear and increment of address latches
// - Low latch driven onto bus when enabled
// - ROM chip select one-of-eight from bits 8-10
// - ROM board select by bits 11-13 and read
// - RAM write mode while write control low
// - RAM bank select one-of-eight from bits 10-12
// - RAM drives bus only selected and read
// - Input port one-of-eight from bits 9-11
// - Input decoder active only while strobe low
// - Output port decode gives 24 ports
// - Output decoder enabled only while strobe low
// - Selected output latch captures system bus
// - Memory read gate marks memory owning bus
module bdm_bridge
  import bdm_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire bdm_ctrl_s                   ctrl,
  input  wire logic                        low_addr_latch_strobe,
  input  wire logic                        high_addr_latch_strobe,
  input  wire logic                        addr_latch_clear,
  input  wire logic                        addr_latch_increment,
  input  wire logic [DATA_W-1:0]           processor_data_lines_in,
  input  wire logic [DATA_W-1:0]           system_data_bus_in,
  input  wire logic [2:0]                  rom_board_code,
  input  wire logic [2:0]                  ram_bank_code,
  input  wire logic [NUM_SEL*PORT_W-1:0]   input_port_data,
  output logic      [DATA_W-1:0]           processor_data_lines_out,
  output logic                             processor_data_lines_oe,
  output logic      [DATA_W-1:0]           system_data_bus_out,
  output logic                             system_data_bus_oe,
  output logic      [ADDR_W-1:0]           address,
  output logic                             cycle_code_bit_one,
  output logic                             cycle_code_bit_two,
  output logic                             upper_addr_decode,
  output logic      [NUM_SEL-1:0]          rom_chip_select_n,
  output logic                             rom_board_select,
  output logic      [NUM_SEL-1:0]          ram_bank_select,
  output logic                             ram_write_mode,
  output logic                             ram_bus_drive,
  output logic      [NUM_SEL-1:0]          input_port_select,
  output logic      [NUM_OUT_PORTS-1:0]    output_port_strobe,
  output logic      [NUM_OUT_PORTS*PORT_W-1:0] output_port_data
);

  function automatic logic [NUM_SEL-1:0] one_of_eight(
    input logic [2:0] code,
    input logic       en
  );
    logic [NUM_SEL-1:0] r;
    r = '0;
    if (en) begin
      r[code] = 1'b1;
    end
    return r;
  endfunction : one_of_eight

  // Three-bit address field against a configured code, gated
  function automatic logic code_match(
    input logic [2:0] bits,
    input logic [2:0] code,
    input logic       gate
  );
    logic r;
    r = gate && (bits == code);
    return r;
  endfunction : code_match

  // Output group from bits 13:12; code 00 owns no ports
  function automatic logic [NUM_OUT_GRP-1:0] out_group(
    input logic [1:0] grp
  );
    logic [NUM_OUT_GRP-1:0] r;
    r = '0;
    case (grp)
      OUT_GRP_01: r[0] = 1'b1;
      OUT_GRP_10: r[1] = 1'b1;
      OUT_GRP_11: r[2] = 1'b1;
      default:    r = '0;
    endcase
    return r;
  endfunction : out_group

  // Who drives the system data bus this cycle
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_ECHO,
    SRC_PORT,
    SRC_SWITCH
  } bdm_src_e;

  typedef struct packed {
    logic [DATA_W-1:0]        proc_out;
    logic                     proc_oe;
    logic [DATA_W-1:0]        sys_out;
    logic                     sys_oe;
    logic                     upper;
    logic [NUM_SEL-1:0]       rom_cs_n;
    logic                     rom_sel;
    logic [NUM_SEL-1:0]       ram_sel;
    logic                     ram_wr;
    logic                     ram_drv;
    logic [NUM_SEL-1:0]       in_sel;
    logic [NUM_OUT_PORTS-1:0] out_stb;
  } bdm_state_s;

  bdm_state_s s_q;
  bdm_state_s s_d;

  logic [LOW_W-1:0]  low_val;
  logic [HIGH_W-1:0] high_val;
  logic [1:0]        cc_val;
  logic              low_carry;
  logic              high_carry;
  logic [ADDR_W-1:0] a;
  logic [2:0]        port_code;
  logic [1:0]        grp_code;
  logic [NUM_OUT_PORTS-1:0] out_sel;
  logic [NUM_OUT_GRP-1:0] grp_hit;
  logic [2:0]        rom_chip_code;
  logic [2:0]        rom_brd_bits;
  logic [2:0]        ram_bank_bits;
  logic              sw_to_sys;
  logic              sw_to_proc;
  bdm_src_e          sys_src;

  // Low byte counter; carry feeds the high byte on increment
  bdm_addr_latch #(.WIDTH(LOW_W), .RST_VAL(LOW_RST)) u_low (
    .clock     (clock),
    .resetn    (resetn),
    .strobe    (low_addr_latch_strobe),
    .load_data (processor_data_lines_in),
    .clear     (addr_latch_clear),
    .increment (!addr_latch_increment),
    .carry_in  (1'b1),
    .value     (low_val),
    .carry_out (low_carry)
  );

  bdm_addr_latch #(.WIDTH(HIGH_W), .RST_VAL(HIGH_RST)) u_high (
    .clock     (clock),
    .resetn    (resetn),
    .strobe    (high_addr_latch_strobe),
    .load_data (processor_data_lines_in[HIGH_W-1:0]),
    .clear     (addr_latch_clear),
    .increment (!addr_latch_increment),
    .carry_in  (low_carry),
    .value     (high_val),
    .carry_out (high_carry)
  );

  bdm_addr_latch #(.WIDTH(2), .RST_VAL(CC_RST)) u_cc (
    .clock     (clock),
    .resetn    (resetn),
    .strobe    (high_addr_latch_strobe),
    .load_data (processor_data_lines_in[DATA_W-1:HIGH_W]),
    .clear     (addr_latch_clear),
    .increment (1'b0),
    .carry_in  (high_carry),
    .value     (cc_val),
    .carry_out ()
  );

  assign a         = {high_val, low_val};
  assign port_code = a[PORT_SEL_LSB+:3];
  assign grp_code  = a[UPPER_LSB+:2];

  assign rom_chip_code = a[ROM_SEL_LSB+:3];
  assign rom_brd_bits  = a[ROM_BRD_LSB+:3];
  assign ram_bank_bits = a[RAM_SEL_LSB+:3];
  assign grp_hit       = out_group(grp_code);

  // Switch direction follows the direction control while enabled
  assign sw_to_sys  = ctrl.bus_switch_enable
                      && ctrl.processor_drives_bus;
  assign sw_to_proc = ctrl.bus_switch_enable
                      && !ctrl.processor_drives_bus;

  // Output port select: group by bits 13:12, port by bits 11:9
  genvar gg;
  generate
    for (gg = 0; gg < NUM_OUT_GRP; gg++) begin : g_grp
      assign out_sel[gg*NUM_SEL+:NUM_SEL] =
        one_of_eight(port_code,
                     grp_hit[gg] && !ctrl.output_strobe_n);
    end
  endgenerate

  // System bus source priority: latch echo, input port, switch
  always_comb begin
    if (!ctrl.latched_low_onto_bus_n) begin
      sys_src = SRC_ECHO;
    end else if (!ctrl.input_strobe_n) begin
      sys_src = SRC_PORT;
    end else if (sw_to_sys) begin
      sys_src = SRC_SWITCH;
    end else begin
      sys_src = SRC_NONE;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.upper    = a[UPPER_LSB] | a[UPPER_LSB+1];
    s_d.rom_cs_n = ~one_of_eight(rom_chip_code, 1'b1);
    s_d.rom_sel  = code_match(rom_brd_bits, rom_board_code,
                              ctrl.memory_read_gate);
    s_d.ram_sel  = one_of_eight(ram_bank_bits, 1'b1);
    s_d.ram_wr   = !ctrl.write_n;
    s_d.ram_drv  = code_match(ram_bank_bits, ram_bank_code,
                              ctrl.memory_read_gate);
    s_d.in_sel   = one_of_eight(port_code,
                                !ctrl.input_strobe_n);
    s_d.out_stb  = out_sel;
    s_d.proc_oe  = 1'b0;
    s_d.sys_oe   = 1'b0;
    case (sys_src)
      SRC_ECHO: begin
        s_d.sys_out = low_val;
        s_d.sys_oe  = 1'b1;
      end
      SRC_PORT: begin
        s_d.sys_out = input_port_data[port_code*PORT_W+:DATA_W];
        s_d.sys_oe  = 1'b1;
      end
      SRC_SWITCH: begin
        s_d.sys_out = processor_data_lines_in;
        s_d.sys_oe  = 1'b1;
      end
      default: begin
        s_d.sys_oe  = 1'b0;
      end
    endcase
    if (sw_to_proc) begin
      s_d.proc_out = system_data_bus_in;
      s_d.proc_oe  = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q.proc_out <= '0;
      s_q.proc_oe  <= 1'b0;
      s_q.sys_out  <= '0;
      s_q.sys_oe   <= 1'b0;
      s_q.upper    <= 1'b0;
      s_q.rom_cs_n <= '1;
      s_q.rom_sel  <= 1'b0;
      s_q.ram_sel  <= '0;
      s_q.ram_wr   <= 1'b0;
      s_q.ram_drv  <= 1'b0;
      s_q.in_sel   <= '0;
      s_q.out_stb  <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_OUT_PORTS; g++) begin : g_out
      bdm_out_latch #(.WIDTH(PORT_W)) u_olat (
        .clock    (clock),
        .resetn   (resetn),
        .strobe   (s_q.out_stb[g]),
        .data_in  (system_data_bus_in),
        .data_out (output_port_data[g*PORT_W+:PORT_W])
      );
    end
  endgenerate

  assign processor_data_lines_out = s_q.proc_out;
  assign processor_data_lines_oe  = s_q.proc_oe;
  assign system_data_bus_out      = s_q.sys_out;
  assign system_data_bus_oe       = s_q.sys_oe;
  assign address                  = a;
  assign cycle_code_bit_one       = cc_val[0];
  assign cycle_code_bit_two       = cc_val[1];
  assign upper_addr_decode        = s_q.upper;
  assign rom_chip_select_n        = s_q.rom_cs_n;
  assign rom_board_select         = s_q.rom_sel;
  assign ram_bank_select          = s_q.ram_sel;
  assign ram_write_mode           = s_q.ram_wr;
  assign ram_bus_drive            = s_q.ram_drv;
  assign input_port_select        = s_q.in_sel;
  assign output_port_strobe       = s_q.out_stb;

endmodule : bdm_bridge

// >>> dv/bdm_proc_model.sv
`timescale 1ns/100ps
module bdm_proc_model
  import bdm_pkg::*;
#(
  parameter logic [1:0] WRITE_CC = 2'h2
) (
  input  wire logic       clock,
  input  wire logic [1:0] cycle_code,
  input  wire logic       data_state,
  input  wire logic [7:0] byte_out,
  input  wire logic [7:0] dut_out,
  input  wire logic       dut_oe,
  output logic            drives_bus,
  output logic      [7:0] lines
);
  logic [7:0] last_q = 8'h00;
  // Drives the bus unless data state of a non-write cycle
  assign drives_bus = !(data_state && cycle_code != WRITE_CC);
  // Released lines show a changing pattern
  assign lines = dut_oe ? dut_out : (drives_bus ? byte_out : ~last_q);
  always @(posedge clock) last_q <= lines;
endmodule : bdm_proc_model

// >>> dv/bdm_bridge_assertions.sv
`timescale 1ns/100ps
module bdm_bridge_assertions
  import bdm_pkg::*;
(
  input wire logic                     clock,
  input wire logic                     resetn,
  input wire bdm_ctrl_s                ctrl,
  input wire logic                     low_addr_latch_strobe,
  input wire logic                     high_addr_latch_strobe,
  input wire logic                     addr_latch_clear,
  input wire logic                     addr_latch_increment,
  input wire logic [DATA_W-1:0]        processor_data_lines_in,
  input wire logic [ADDR_W-1:0]        address,
  input wire logic                     cycle_code_bit_one,
  input wire logic                     cycle_code_bit_two,
  input wire logic                     upper_addr_decode,
  input wire logic [NUM_SEL-1:0]       rom_chip_select_n,
  input wire logic [NUM_SEL-1:0]       input_port_select,
  input wire logic [NUM_OUT_PORTS-1:0] output_port_strobe
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  logic up_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) up_q <= 1'b0;
    else up_q <= 1'b1;
  end
  property p_low_load;
    low_addr_latch_strobe && !addr_latch_clear
      |=> address[7:0] == $past(processor_data_lines_in);
  endproperty
  a_low_load: assert property (p_low_load) else $error("low load");
  property p_high_load;
    high_addr_latch_strobe && !addr_latch_clear |=> {cycle_code_bit_two,
      cycle_code_bit_one, address[13:8]} == $past(processor_data_lines_in);
  endproperty
  a_high_load: assert property (p_high_load) else $error("high load");
  property p_clear;
    addr_latch_clear |=> address == 14'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear");
  property p_count;
    !(addr_latch_clear || low_addr_latch_strobe || high_addr_latch_strobe)
      |=> address == $past(address) + 14'(!$past(addr_latch_increment));
  endproperty
  a_count: assert property (p_count) else $error("hold");
  property p_upper;
    upper_addr_decode == (|$past(address[13:12]));
  endproperty
  a_upper: assert property (p_upper) else $error("upper");
  property p_rom_cs;
    up_q |-> rom_chip_select_n == ~(8'h01 << $past(address[10:8]));
  endproperty
  a_rom_cs: assert property (p_rom_cs) else $error("rom cs");
  property p_in_sel;
    up_q |-> input_port_select == ($past(ctrl.input_strobe_n) ? 8'h00
      : 8'h01 << $past(address[11:9]));
  endproperty
  a_in_sel: assert property (p_in_sel) else $error("in sel");
  property p_out_stb;
    up_q |-> output_port_strobe == (($past(ctrl.output_strobe_n) ||
      $past(address[13:12]) == 2'h0) ? 24'h0 : 24'h1 <<
      {$past(address[13:12]) - 2'h1, $past(address[11:9])});
  endproperty
  a_out_stb: assert property (p_out_stb) else $error("out");
  c_low: cover property (low_addr_latch_strobe);
  c_inc: cover property (!addr_latch_increment);
  c_out: cover property (|output_port_strobe);
endmodule : bdm_bridge_assertions

bind bdm_bridge bdm_bridge_assertions i_chk (.*);

// >>> dv/bdm_bridge_bench.sv
`timescale 1ns/100ps
module bdm_bridge_bench
  import bdm_pkg::*;
;
  logic         clock = 1'b0;
  logic         resetn = 1'b0;
  bdm_ctrl_s    cb = 7'h17;
  bdm_ctrl_s    ctrl;
  logic         low_stb = 1'b0;
  logic         high_stb = 1'b0;
  logic         clr = 1'b0;
  logic         inc_n = 1'b1;
  logic         ds = 1'b0;
  logic         pdb, poe, soe, cc1, cc2, upper, rbs, rbd, wm;
  logic [7:0]   pbyte = 8'h00;
  logic [7:0]   sbyte = 8'hff;
  logic [7:0]   plines, pout, sys_in, sout, rcs_n, rbank, v;
  logic [2:0]   rcode = 3'h0;
  logic [2:0]   kcode = 3'h0;
  logic [63:0]  in_data = 64'h0;
  logic [13:0]  addr, a;
  logic [191:0] odata, exp_od;
  logic [8:0]   e;
  int           seed = 13052;
  int           err_total = 0;
  int           num_checks = 0;
  int           cycles = 0;
  always #2 clock = ~clock;
  always_comb begin
    ctrl = cb;
    ctrl.processor_drives_bus = pdb;
  end
  assign sys_in = soe ? sout : sbyte;
  bdm_proc_model i_proc (.clock(clock), .cycle_code({cc2, cc1}),
    .data_state(ds), .byte_out(pbyte), .dut_out(pout), .dut_oe(poe),
    .drives_bus(pdb), .lines(plines));
  bdm_bridge i_dut (.clock(clock), .resetn(resetn), .ctrl(ctrl),
    .low_addr_latch_strobe(low_stb), .high_addr_latch_strobe(high_stb),
    .addr_latch_clear(clr), .addr_latch_increment(inc_n),
    .processor_data_lines_in(plines), .system_data_bus_in(sys_in),
    .rom_board_code(rcode), .ram_bank_code(kcode),
    .input_port_data(in_data), .processor_data_lines_out(pout),
    .processor_data_lines_oe(poe), .system_data_bus_out(sout),
    .system_data_bus_oe(soe), .address(addr), .cycle_code_bit_one(cc1),
    .cycle_code_bit_two(cc2), .upper_addr_decode(upper),
    .rom_chip_select_n(rcs_n), .rom_board_select(rbs),
    .ram_bank_select(rbank), .ram_write_mode(wm), .ram_bus_drive(rbd),
    .input_port_select(), .output_port_strobe(),
    .output_port_data(odata));
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end
  function automatic logic [8:0] f_sys(bdm_ctrl_s c);
    if (!c.latched_low_onto_bus_n) return {1'b1, a[7:0]};
    if (!c.input_strobe_n) return {1'b1, in_data[a[11:9]*8 +: 8]};
    if (c.bus_switch_enable && c.processor_drives_bus) return {1'b1, pbyte};
    return 9'h0;
  endfunction : f_sys
  task automatic results();
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task automatic chk(logic [191:0] got, logic [191:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_n(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_n
  task automatic load(logic [13:0] la, logic [1:0] cc);
    @(posedge clock);
    ds <= 1'b0;
    @(posedge clock);
    low_stb <= 1'b1;
    pbyte <= la[7:0];
    @(posedge clock);
    low_stb <= 1'b0;
    high_stb <= 1'b1;
    pbyte <= {cc, la[13:8]};
    @(posedge clock);
    high_stb <= 1'b0;
    wait_n(2);
  endtask : load
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    wait_n(1);
    chk({addr, rcs_n}, {14'h0, 8'hfe});
    a = 14'h00ff;
    load(a, 2'h3);
    chk({cc2, cc1, addr, upper}, {2'h3, a, 1'b0});
    @(posedge clock);
    inc_n <= 1'b0;
    @(posedge clock);
    inc_n <= 1'b1;
    wait_n(2);
    chk(addr, 14'h0100);
    load(14'h3a5c, 2'h1);
    chk(upper, 1'b1);
    @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    wait_n(2);
    chk({addr, upper}, 15'h0);
    exp_od = '0;
    for (int g = 0; g < 4; g++) begin
      for (int k = 0; k < 8; k++) begin
        a = {g[1:0], k[2:0], 9'h0};
        v = 8'($random(seed));
        load(a, 2'h1);
        @(posedge clock);
        sbyte <= v;
        cb.output_strobe_n <= 1'b0;
        @(posedge clock);
        cb.output_strobe_n <= 1'b1;
        wait_n(3);
        if (g != 0) exp_od[((g-1)*8+k)*8 +: 8] = v;
        chk(odata, exp_od);
      end
    end
    for (int i = 0; i < 40; i++) begin
      a = 14'($random(seed));
      load(a, 2'($random(seed)));
      @(posedge clock);
      cb <= 7'($random(seed));
      ds <= 1'($random(seed));
      rcode <= 3'($random(seed));
      kcode <= 3'($random(seed));
      in_data <= {$random(seed), $random(seed)};
      sbyte <= 8'($random(seed));
      pbyte <= 8'($random(seed));
      wait_n(3);
      e = f_sys(ctrl);
      chk({soe, sout & {8{soe}}}, e);
      chk({poe, pout & {8{poe}}},
          (cb.bus_switch_enable && !pdb) ?
          {1'b1, e[8] ? e[7:0] : sbyte} : 9'h0);
      chk({rbs, rbd, rbank, wm},
          {cb.memory_read_gate && a[13:11] == rcode,
          cb.memory_read_gate && a[12:10] == kcode,
          8'h1 << a[12:10], !cb.write_n});
    end
    results();
  end
endmodule : bdm_bridge_bench
